// [logic/hspwm_pkg.sv]
`default_nettype none
package hspwm_pkg;

	// Data path widths and channel count
	localparam int CNT_W      = 16;
	localparam int NUM_CH     = 4;
	localparam int DIV_W      = 3;
	localparam int PRESCALE_W = 7;
	localparam int OVR_W      = 2;

	// Positions inside a two-bit level field
	localparam int LVL_HIGH_BIT = 1;
	localparam int LVL_LOW_BIT  = 0;

	// Values after reset
	localparam logic [CNT_W-1:0]      PERIOD_RESET   = 16'h00ff;
	localparam logic [CNT_W-1:0]      COUNT_RESET    = 16'h0000;
	localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 7'h00;

	// Timing
	localparam int CLK_PERIOD_NS     = 8;
	localparam int GLITCH_NS         = 8;
	localparam int MIN_PULSE_CYCLES  =
		(GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_PULSE_NS     = 100;
	localparam int SYNC_PULSE_CYCLES =
		(SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_CNT_W        = 4;
	localparam logic [SYNC_CNT_W-1:0] SYNC_LOAD =
		SYNC_CNT_W'(SYNC_PULSE_CYCLES);
	localparam logic [SYNC_CNT_W-1:0] MIN_HOLD =
		SYNC_CNT_W'(MIN_PULSE_CYCLES);

	// Output modes
	typedef enum logic [1:0] {
		MODE_COMPLEMENTARY,
		MODE_REDUNDANT,
		MODE_PUSH_PULL,
		MODE_INDEPENDENT
	} out_mode_t;

endpackage : hspwm_pkg
`default_nettype wire

// [logic/pwm_output_stage.sv]
`timescale 1ns/1ps
`default_nettype none
module pwm_output_stage #(
	parameter int W = hspwm_pkg::CNT_W
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_n,
	// Timing
	input  wire logic         tick,
	input  wire logic         enable,
	input  wire logic         dt_en,
	// Generated requests
	input  wire logic         h_req,
	input  wire logic         l_req,
	// Fault handling
	input  wire logic         fault_active,
	input  wire logic [1:0]   fault_level,
	// Dead time
	input  wire logic [W-1:0] dead_time,
	input  wire logic [W-1:0] alternate_deadtime_value,
	// Pin control
	input  wire logic         swap,
	input  wire logic         high_override_enable,
	input  wire logic         low_override_enable,
	input  wire logic [1:0]   override_level_field,
	input  wire logic         high_pin_owner_bit,
	input  wire logic         low_pin_owner_bit,
	input  wire logic         gpio_high_level,
	input  wire logic         gpio_low_level,
	// Pins
	output logic              high_side_output,
	output logic              low_side_output
);

	typedef struct packed {
		logic         h;
		logic         l;
		logic [W-1:0] dt;
		logic [hspwm_pkg::SYNC_CNT_W-1:0] hold;
		logic         pin_h;
		logic         pin_l;
	} stage_t;

	stage_t st;
	stage_t next_st;
	logic   rh;
	logic   rl;
	logic   gap;
	logic   ph;
	logic   pl;
	logic [W-1:0] dt_load;

	always_comb begin
		next_st = st;
		rh = swap ? l_req : h_req;
		rl = swap ? h_req : l_req;
		if (fault_active) begin
			rh = fault_level[hspwm_pkg::LVL_HIGH_BIT];
			rl = fault_level[hspwm_pkg::LVL_LOW_BIT];
		end
		// Full-width alternate count, never clipped
		dt_load = fault_active ? alternate_deadtime_value : dead_time;
		gap = dt_en && !(rh && rl);
		if (!enable) begin
			next_st.h  = 1'b0;
			next_st.l  = 1'b0;
			next_st.dt = '0;
		end else begin
			next_st.h = st.h & rh;
			next_st.l = st.l & rl;
			// In complementary mode any falling edge rearms the gap, whatever its cause
			if (gap && ((st.h && !rh) || (st.l && !rl))) begin
				next_st.dt = dt_load;
			end else if (tick && st.dt != '0) begin
				next_st.dt = st.dt - W'(1);
			end
			if (rh && !st.h && (!gap || (!st.l && !rl && st.dt == '0)))
				next_st.h = 1'b1;
			if (rl && !st.l && (!gap || (!st.h && !rh && st.dt == '0)))
				next_st.l = 1'b1;
		end
		ph = high_override_enable ?
			override_level_field[hspwm_pkg::LVL_HIGH_BIT] : next_st.h;
		pl = low_override_enable ?
			override_level_field[hspwm_pkg::LVL_LOW_BIT] : next_st.l;
		// Fault entry holds at least one full clock
		if (fault_active && st.hold == '0)
			next_st.hold = hspwm_pkg::MIN_HOLD;
		else if (!fault_active && st.hold != '0)
			next_st.hold = st.hold - hspwm_pkg::SYNC_CNT_W'(1);
		next_st.pin_h = high_pin_owner_bit ? ph : gpio_high_level;
		next_st.pin_l = low_pin_owner_bit ? pl : gpio_low_level;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign high_side_output = st.pin_h;
	assign low_side_output  = st.pin_l;

endmodule : pwm_output_stage
`default_nettype wire

// [logic/high_speed_pwm_output_control.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Per-channel owner bits give pins to PWM/GPIO
// - Module enable bit starts whole generator
// - Two-bit override field sets safe pin levels
// - Per-side override enables replace generated waveform
// - Enabling with pins owned emits no spurious pulse
// - External reset in off time restarts period
// - Reset held through on time is ignored
// - External reset works with outputs swapped
// - Sync output pulses from secondary time base
// - Clean start from override at any divider
// - Fault drives defined state without glitch
// - Alternate dead time uses full programmed count
// - Immediate duty transitions keep dead time
// - Duty to zero leaves no residual pulse
// - Phase writes keep complementary dead time
// - Trigger compare match fires from first match
// - Push-pull period write gives no double pulse
// - Outputs jitter-free at every divider setting
// - Buffered period, duty, phase update together
// - Time-base select picks primary or secondary
module high_speed_pwm_output_control #(
	parameter int N = hspwm_pkg::NUM_CH,
	parameter int W = hspwm_pkg::CNT_W
) (
	// Clock and reset
	input  wire logic                        mclk,
	input  wire logic                        arst_n,
	// Time base control
	input  wire logic                        module_enable_bit,
	input  wire logic [hspwm_pkg::DIV_W-1:0] clock_divider_select,
	input  wire logic [W-1:0]                primary_master_period,
	input  wire logic [W-1:0]                secondary_master_period,
	// Channel control
	input  wire logic [N-1:0]                time_base_select_bit,
	input  wire hspwm_pkg::out_mode_t [N-1:0] output_mode,
	input  wire logic [N-1:0]                immediate_update,
	input  wire logic [N-1:0]                swap,
	// Channel timing values
	input  wire logic [N-1:0][W-1:0]         channel_duty_value,
	input  wire logic [N-1:0][W-1:0]         channel_phase_value,
	input  wire logic [N-1:0][W-1:0]         dead_time,
	input  wire logic [N-1:0][W-1:0]         alternate_deadtime_value,
	// Trigger compares
	input  wire logic [N-1:0][W-1:0]         primary_trigger_compare,
	input  wire logic [N-1:0][W-1:0]         secondary_trigger_compare,
	// External period reset
	input  wire logic [N-1:0]                ext_reset_enable,
	input  wire logic [N-1:0]                ext_reset_in,
	// Fault
	input  wire logic [N-1:0]                fault_in,
	input  wire logic [N-1:0][1:0]           fault_level_field,
	// Channel I/O control
	input  wire logic [N-1:0]                high_pin_owner_bit,
	input  wire logic [N-1:0]                low_pin_owner_bit,
	input  wire logic [N-1:0]                high_override_enable,
	input  wire logic [N-1:0]                low_override_enable,
	input  wire logic [N-1:0][1:0]           override_level_field,
	input  wire logic [N-1:0]                gpio_high_level,
	input  wire logic [N-1:0]                gpio_low_level,
	// Pins and events
	output logic [N-1:0]                     high_side_output,
	output logic [N-1:0]                     low_side_output,
	output logic [N-1:0]                     trigger_event,
	output logic                             secondary_sync_output
);

	typedef struct packed {
		logic                                en;
		logic [hspwm_pkg::PRESCALE_W-1:0]    pre;
		logic                                tick;
		logic [W-1:0]                        pri_cnt;
		logic [W-1:0]                        sec_cnt;
		logic [W-1:0]                        pri_per;
		logic [W-1:0]                        sec_per;
		logic [hspwm_pkg::SYNC_CNT_W-1:0]    sync_cnt;
		logic                                sync;
		logic [N-1:0][W-1:0]                 cnt;
		logic [N-1:0][W-1:0]                 duty;
		logic [N-1:0]                        steer;
		logic [N-1:0]                        xr_block;
		logic [N-1:0]                        trig;
		logic [N-1:0]                        h_req;
		logic [N-1:0]                        l_req;
	} state_t;

	logic [1:0]                       rst_ff;
	logic                             rst_n;
	state_t                           st;
	state_t                           next_st;
	logic [hspwm_pkg::PRESCALE_W-1:0] pre_mask;
	logic                             pri_end;
	logic                             sec_end;
	logic [N-1:0]                     ch_start;
	logic [N-1:0]                     on;
	logic [N-1:0]                     xr;
	logic [N-1:0][W-1:0]              per_sel;

	// Reset release
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_ff <= 2'b00;
		end else begin
			rst_ff <= {rst_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_ff[1];

	// Fixed divide mask, no phase drift between ticks
	assign pre_mask = hspwm_pkg::PRESCALE_W'(
		(1 << clock_divider_select) - 1);
	assign pri_end  = st.pri_cnt >= st.pri_per;
	assign sec_end  = st.sec_cnt >= st.sec_per;

	always_comb begin
		for (int i = 0; i < N; i++) begin
			per_sel[i]  = time_base_select_bit[i] ?
				st.sec_per : st.pri_per;
			ch_start[i] = time_base_select_bit[i] ? sec_end : pri_end;
			// Zero duty never compares true
			on[i] = st.cnt[i] < st.duty[i];
			// Raw generator state, taken before any swap
			xr[i] = ext_reset_enable[i] && ext_reset_in[i] && !on[i] &&
				!st.xr_block[i];
		end
	end

	always_comb begin
		next_st = st;
		next_st.en = module_enable_bit;
		next_st.tick = 1'b0;
		next_st.trig = '0;
		if (!st.en) begin
			// Idle: everything parked at a known start point
			next_st.pre      = hspwm_pkg::PRESCALE_RESET;
			next_st.pri_cnt  = hspwm_pkg::COUNT_RESET;
			next_st.sec_cnt  = hspwm_pkg::COUNT_RESET;
			next_st.pri_per  = primary_master_period;
			next_st.sec_per  = secondary_master_period;
			next_st.sync_cnt = '0;
			next_st.sync     = 1'b0;
			for (int i = 0; i < N; i++) begin
				next_st.cnt[i]  = channel_phase_value[i];
				next_st.duty[i] = channel_duty_value[i];
			end
			next_st.steer    = '0;
			next_st.xr_block = '0;
			next_st.h_req    = '0;
			next_st.l_req    = '0;
		end else begin
			if (st.pre == pre_mask) begin
				next_st.pre  = hspwm_pkg::PRESCALE_RESET;
				next_st.tick = 1'b1;
			end else begin
				next_st.pre = st.pre + hspwm_pkg::PRESCALE_W'(1);
			end
			if (st.tick) begin
				if (pri_end) begin
					next_st.pri_cnt = hspwm_pkg::COUNT_RESET;
					next_st.pri_per = primary_master_period;
				end else begin
					next_st.pri_cnt = st.pri_cnt + W'(1);
				end
				if (sec_end) begin
					next_st.sec_cnt = hspwm_pkg::COUNT_RESET;
					next_st.sec_per = secondary_master_period;
				end else begin
					next_st.sec_cnt = st.sec_cnt + W'(1);
				end
			end
			// Sync pulse at each secondary period start
			if (st.tick && sec_end) begin
				next_st.sync_cnt = hspwm_pkg::SYNC_LOAD;
			end else if (st.sync_cnt != '0) begin
				next_st.sync_cnt = st.sync_cnt - hspwm_pkg::SYNC_CNT_W'(1);
			end
			next_st.sync = next_st.sync_cnt != '0;
			for (int i = 0; i < N; i++) begin
				if (!ext_reset_in[i]) begin
					next_st.xr_block[i] = 1'b0;
				end else if (on[i]) begin
					next_st.xr_block[i] = 1'b1;
				end
				if (st.tick) begin
					// Compare on the current count, first match included
					next_st.trig[i] =
						st.cnt[i] == primary_trigger_compare[i] ||
						st.cnt[i] == secondary_trigger_compare[i];
					if (ch_start[i]) begin
						// Phase and duty land with the new period
						next_st.cnt[i]  = channel_phase_value[i];
						next_st.duty[i] = channel_duty_value[i];
						next_st.steer[i] = ~st.steer[i];
					end else if (xr[i]) begin
						next_st.cnt[i]   = hspwm_pkg::COUNT_RESET;
						next_st.steer[i] = ~st.steer[i];
					end else if (st.cnt[i] >= per_sel[i]) begin
						// Wrap only on the shadowed period, one pulse
						next_st.cnt[i] = hspwm_pkg::COUNT_RESET;
					end else begin
						next_st.cnt[i] = st.cnt[i] + W'(1);
					end
					if (immediate_update[i])
						next_st.duty[i] = channel_duty_value[i];
				end
				unique case (output_mode[i])
					hspwm_pkg::MODE_COMPLEMENTARY: begin
						next_st.h_req[i] = on[i];
						next_st.l_req[i] = !on[i];
					end
					hspwm_pkg::MODE_REDUNDANT: begin
						next_st.h_req[i] = on[i];
						next_st.l_req[i] = on[i];
					end
					hspwm_pkg::MODE_PUSH_PULL: begin
						next_st.h_req[i] = on[i] && st.steer[i];
						next_st.l_req[i] = on[i] && !st.steer[i];
					end
					hspwm_pkg::MODE_INDEPENDENT: begin
						next_st.h_req[i] = on[i];
						next_st.l_req[i] = on[i];
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st         <= '0;
			st.pri_per <= hspwm_pkg::PERIOD_RESET;
			st.sec_per <= hspwm_pkg::PERIOD_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign trigger_event         = st.trig;
	assign secondary_sync_output = st.sync;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			pwm_output_stage #(
				.W(W)
			) u_stage (
				.mclk                     (mclk),
				.rst_n                    (rst_n),
				.tick                     (st.tick),
				.enable                   (st.en),
				.dt_en                    (output_mode[g] ==
					hspwm_pkg::MODE_COMPLEMENTARY),
				.h_req                    (st.h_req[g]),
				.l_req                    (st.l_req[g]),
				.fault_active             (fault_in[g]),
				.fault_level              (fault_level_field[g]),
				.dead_time                (dead_time[g]),
				.alternate_deadtime_value (alternate_deadtime_value[g]),
				.swap                     (swap[g]),
				.high_override_enable     (high_override_enable[g]),
				.low_override_enable      (low_override_enable[g]),
				.override_level_field     (override_level_field[g]),
				.high_pin_owner_bit       (high_pin_owner_bit[g]),
				.low_pin_owner_bit        (low_pin_owner_bit[g]),
				.gpio_high_level          (gpio_high_level[g]),
				.gpio_low_level           (gpio_low_level[g]),
				.high_side_output         (high_side_output[g]),
				.low_side_output          (low_side_output[g])
			);
		end
	endgenerate

endmodule : high_speed_pwm_output_control
`default_nettype wire

// [bench/hspwm_check_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module hspwm_check_sva #(
	parameter int N = hspwm_pkg::NUM_CH,
	parameter int W = hspwm_pkg::CNT_W
) (
	// Clock and reset
	input  wire logic                         mclk,
	input  wire logic                         arst_n,
	// Controls
	input  wire logic                         module_enable_bit,
	input  wire hspwm_pkg::out_mode_t [N-1:0] output_mode,
	input  wire logic [N-1:0]                 fault_in,
	input  wire logic [N-1:0]                 high_pin_owner_bit,
	input  wire logic [N-1:0]                 low_pin_owner_bit,
	input  wire logic [N-1:0]                 high_override_enable,
	input  wire logic [N-1:0]                 low_override_enable,
	input  wire logic [N-1:0][1:0]            override_level_field,
	input  wire logic [N-1:0]                 gpio_high_level,
	input  wire logic [N-1:0]                 gpio_low_level,
	// Outputs
	input  wire logic [N-1:0]                 high_side_output,
	input  wire logic [N-1:0]                 low_side_output,
	input  wire logic [N-1:0]                 trigger_event,
	input  wire logic                         secondary_sync_output
);
	logic [2:0] rdy;
	logic [4:0] idle;
	logic [4:0] slen;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdy  <= 3'h0;
			idle <= 5'h00;
			slen <= 5'h00;
		end else begin
			rdy  <= {rdy[1:0], 1'b1};
			idle <= module_enable_bit ? 5'h00 : idle + {4'h0, ~&idle};
			slen <= secondary_sync_output ? slen + 5'h01 : 5'h00;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rdy[2]);
	sequence comp_run;
		output_mode[0] == hspwm_pkg::MODE_COMPLEMENTARY && !fault_in[0] &&
		high_pin_owner_bit[0] && low_pin_owner_bit[0] &&
		!high_override_enable[0] && !low_override_enable[0];
	endsequence
	sequence idle_high;
		!module_enable_bit && !fault_in[0] && high_pin_owner_bit[0] &&
		!high_override_enable[0];
	endsequence
	ovr_high_a: assert property (
		high_pin_owner_bit[0] && high_override_enable[0]
		|=> high_side_output[0] == $past(override_level_field[0][1]))
		else $error("high pin misses override level");
	ovr_low_a: assert property (
		low_pin_owner_bit[0] && low_override_enable[0]
		|=> low_side_output[0] == $past(override_level_field[0][0]))
		else $error("low pin misses override level");
	gpio_high_a: assert property (
		!high_pin_owner_bit[0] |=> high_side_output[0] == $past(gpio_high_level[0]))
		else $error("high pin not driven by port logic");
	gpio_low_a: assert property (
		!low_pin_owner_bit[0] |=> low_side_output[0] == $past(gpio_low_level[0]))
		else $error("low pin not driven by port logic");
	dead_gap_a: assert property (
		comp_run [*3] |-> !(high_side_output[0] && low_side_output[0]))
		else $error("complementary pins high together");
	idle_quiet_a: assert property (
		idle_high [*4] |-> !high_side_output[0])
		else $error("pulse on pin while generator stopped");
	idle_trig_a: assert property (
		idle == 5'h1f |-> !trigger_event[0])
		else $error("trigger while generator stopped");
	idle_sync_a: assert property (
		idle == 5'h1f |-> !secondary_sync_output)
		else $error("sync pulse while generator stopped");
	sync_width_a: assert property (
		$fell(secondary_sync_output) |-> slen == 5'h0d)
		else $error("sync pulse width wrong");
endmodule : hspwm_check_sva
bind high_speed_pwm_output_control hspwm_check_sva #(.N(N), .W(W)) check_inst (
	.mclk(mclk), .arst_n(arst_n), .module_enable_bit(module_enable_bit),
	.output_mode(output_mode), .fault_in(fault_in),
	.high_pin_owner_bit(high_pin_owner_bit),
	.low_pin_owner_bit(low_pin_owner_bit),
	.high_override_enable(high_override_enable),
	.low_override_enable(low_override_enable),
	.override_level_field(override_level_field),
	.gpio_high_level(gpio_high_level), .gpio_low_level(gpio_low_level),
	.high_side_output(high_side_output), .low_side_output(low_side_output),
	.trigger_event(trigger_event),
	.secondary_sync_output(secondary_sync_output));
`default_nettype wire

// [bench/gate_and_slave_model.sv]
`timescale 1ns/1ps
`default_nettype none
module gate_and_slave_model (
	// Clock and control
	input  wire logic   mclk,
	input  wire logic   clear,
	// Observed pins
	input  wire logic   gate_high,
	input  wire logic   gate_low,
	input  wire logic   sync_in,
	// Counts
	output logic [15:0] high_rises,
	output logic [15:0] sync_rises,
	output logic [15:0] overlap
);
	logic prev_h;
	logic prev_s;
	always_ff @(posedge mclk) begin
		prev_h <= gate_high;
		prev_s <= sync_in;
		if (clear) begin
			high_rises <= 16'h0000;
			sync_rises <= 16'h0000;
			overlap    <= 16'h0000;
		end else begin
			if (gate_high && !prev_h) high_rises <= high_rises + 16'h0001;
			if (sync_in && !prev_s) sync_rises <= sync_rises + 16'h0001;
			if (gate_high && gate_low) overlap <= overlap + 16'h0001;
		end
	end
endmodule : gate_and_slave_model
`default_nettype wire

// [bench/high_speed_pwm_output_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
module high_speed_pwm_output_control_test;
	localparam int N = hspwm_pkg::NUM_CH;
	typedef struct packed {
		logic [7:0] cfg;
		logic [1:0] pins;
	} row_t;
	localparam row_t ROWS [7] = '{'{8'h02, 2'h2}, '{8'h3d, 2'h1},
		'{8'hf8, 2'h2}, '{8'hf7, 2'h1}, '{8'hec, 2'h2}, '{8'h83, 2'h1},
		'{8'h56, 2'h3}};
	logic                         mclk   = 1'b0;
	logic                         arst_n = 1'b0;
	logic                         en     = 1'b0;
	logic [2:0]                   div    = 3'h0;
	logic [15:0]                  pper   = 16'h0003;
	logic [15:0]                  sper   = 16'h00ff;
	logic [15:0]                  duty   = 16'h0002;
	logic [15:0]                  trp    = 16'h0001;
	logic [15:0]                  trs    = 16'h00ff;
	logic                         tbs    = 1'b0;
	logic                         xen    = 1'b0;
	logic                         xin    = 1'b0;
	logic                         flt    = 1'b0;
	logic                         sw     = 1'b0;
	logic [1:0]                   flv    = 2'h0;
	logic                         oh     = 1'b0;
	logic                         ol     = 1'b0;
	logic                         vh     = 1'b0;
	logic                         vl     = 1'b0;
	logic [1:0]                   lvl    = 2'h0;
	logic                         gh     = 1'b0;
	logic                         gl     = 1'b0;
	logic                         clr    = 1'b1;
	hspwm_pkg::out_mode_t [N-1:0] mode;
	logic [N-1:0]                 hs;
	logic [N-1:0]                 ls;
	logic [N-1:0]                 tev;
	logic                         sync;
	logic [15:0]                  hr;
	logic [15:0]                  sr;
	logic [15:0]                  ov;
	int                           n_errors  = 0;
	int                           tests_run = 0;
	int                           ntrig     = 0;
	always #4 mclk = ~mclk;
	high_speed_pwm_output_control high_speed_pwm_output_control_inst (
		.mclk(mclk), .arst_n(arst_n), .module_enable_bit(en),
		.clock_divider_select(div), .primary_master_period(pper),
		.secondary_master_period(sper), .time_base_select_bit({N{tbs}}),
		.output_mode(mode), .immediate_update({N{1'b0}}), .swap({N{sw}}),
		.channel_duty_value({N{duty}}), .channel_phase_value({N{16'h0000}}),
		.dead_time({N{16'h0000}}), .alternate_deadtime_value({N{16'h0000}}),
		.primary_trigger_compare({N{trp}}),
		.secondary_trigger_compare({N{trs}}), .ext_reset_enable({N{xen}}),
		.ext_reset_in({N{xin}}), .fault_in({N{flt}}),
		.fault_level_field({N{flv}}), .high_pin_owner_bit({N{oh}}),
		.low_pin_owner_bit({N{ol}}), .high_override_enable({N{vh}}),
		.low_override_enable({N{vl}}), .override_level_field({N{lvl}}),
		.gpio_high_level({N{gh}}), .gpio_low_level({N{gl}}),
		.high_side_output(hs), .low_side_output(ls), .trigger_event(tev),
		.secondary_sync_output(sync));
	gate_and_slave_model gate_and_slave_model_inst (
		.mclk(mclk), .clear(clr), .gate_high(hs[0]), .gate_low(ls[0]),
		.sync_in(sync), .high_rises(hr), .sync_rises(sr), .overlap(ov));
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task automatic measure(input int n);
		ntrig = 0;
		@(posedge mclk);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		repeat (n) begin
			@(posedge mclk);
			#1;
			if (tev[0] === 1'b1) ntrig++;
		end
		@(posedge mclk);
	endtask : measure
	task automatic set_mode(input hspwm_pkg::out_mode_t m);
		for (int k = 0; k < N; k++) mode[k] <= m;
	endtask : set_mode
	task automatic report_and_stop;
		if (n_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	initial begin
		set_mode(hspwm_pkg::MODE_COMPLEMENTARY);
		cyc(4);
		check("pins in reset", 16'h0000, {14'h0, hs[0], ls[0]});
		cyc(4);
		arst_n <= 1'b1;
		cyc(4);
		foreach (ROWS[i]) begin
			{oh, ol, vh, vl, lvl, gh, gl} <= ROWS[i].cfg;
			cyc(3);
			check("row pins", {14'h0, ROWS[i].pins}, {14'h0, hs[0], ls[0]});
		end
		{oh, ol, vh, vl, lvl} <= 6'h0c;
		@(posedge mclk);
		en <= 1'b1;
		cyc(2);
		{vh, vl} <= 2'h0;
		cyc(300);
		{oh, ol} <= 2'h3;
		for (int i = 0; i < 4; i++) begin
			div <= 3'(i);
			set_mode(hspwm_pkg::out_mode_t'(i));
			trp <= i[0] ? 16'h00ff : 16'h0001;
			trs <= i[0] ? 16'h0001 : 16'h00ff;
			cyc(16 << i);
			measure(80 << i);
			check("high pulses", (i == 2) ? 16'h000a : 16'h0014, hr);
			check("triggers", 16'h0014, 16'(ntrig));
			if (i[0] == 1'b0) check("overlap", 16'h0000, ov);
		end
		set_mode(hspwm_pkg::MODE_REDUNDANT);
		div <= 3'h0;
		sper <= 16'h0013;
		tbs <= 1'b1;
		cyc(300);
		measure(400);
		check("sync pulses", 16'h0014, sr);
		check("secondary pulses", 16'h0014, hr);
		tbs <= 1'b0;
		xen <= 1'b1;
		xin <= 1'b1;
		cyc(16);
		measure(80);
		check("held reset pulses", 16'h0014, hr);
		sw <= 1'b1;
		cyc(16);
		measure(80);
		check("swapped reset pulses", 16'h0014, hr);
		sw <= 1'b0;
		xen <= 1'b0;
		xin <= 1'b0;
		duty <= 16'h0000;
		cyc(16);
		measure(80);
		check("zero duty pulses", 16'h0000, hr);
		duty <= 16'h0002;
		flt <= 1'b1;
		flv <= 2'h2;
		cyc(16);
		measure(80);
		check("fault pulses", 16'h0000, hr);
		check("fault pins", 16'h0002, {14'h0, hs[0], ls[0]});
		flt <= 1'b0;
		en <= 1'b0;
		cyc(40);
		measure(80);
		check("idle pulses", 16'h0000, hr);
		check("idle triggers", 16'h0000, 16'(ntrig));
		report_and_stop();
	end
endmodule : high_speed_pwm_output_control_test
`default_nettype wire
